/* hdl/spi_dev_end.sv */
// spi_dev_end: device end of the datagram link, holding the register port.
// assumes link pins are synchronous to i_clk and sck is at most i_clk / 4.
`default_nettype none

module spi_dev_end (
  input wire logic i_clk,
  input wire logic i_reset_n,
  spi_link_if.device link,
  input wire logic [spi_frame_pkg::STATUS_USED-1:0] i_status,
  input wire spi_frame_pkg::data_t i_ro_data,
  output logic o_wr_valid,
  output spi_frame_pkg::addr_t o_wr_addr,
  output spi_frame_pkg::data_t o_wr_data,
  output logic o_rd_req,
  output spi_frame_pkg::addr_t o_rd_addr,
  output logic o_frame_drop
);
  import spi_frame_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic sck_q;
  logic sel_q;
  frame_t shift_q;
  count_t bits_q;
  logic miso_q;
  logic miso_oe_q;
  logic pend_q;
  logic last_write_q;
  addr_t last_addr_q;
  data_t last_data_q;
  // status byte lives only in the top of the reply word
  frame_t reply_q;
  logic wr_valid_q;
  addr_t wr_addr_q;
  data_t wr_data_q;
  logic rd_req_q;
  addr_t rd_addr_q;
  logic drop_q;
  data_t rw_mem [RW_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // pin edge decode
  wire in_frame = ~link.select_low;
  wire sck_rise = link.sck & ~sck_q;
  wire sck_fall = ~link.sck & sck_q;
  wire frame_start = sel_q & ~link.select_low;
  wire frame_end = ~sel_q & link.select_low;
  wire frame_ok = (bits_q >= FRAME_COUNT);
  wire take_cmd = frame_end & frame_ok;

  // command fields of the last 40 bits shifted in
  wire cmd_write = shift_q[DIR_POS];
  wire addr_t cmd_addr = shift_q[ADDR_MSB:ADDR_LSB];
  wire data_t cmd_data = shift_q[DATA_MSB:0];

  // register class decode
  wire cmd_is_ro = (cmd_addr <= RO_LAST);
  wire cmd_is_rw = (cmd_addr >= RW_FIRST) && (cmd_addr <= RW_LAST);
  wire last_is_ro = (last_addr_q <= RO_LAST);
  wire last_is_rw = (last_addr_q >= RW_FIRST) && (last_addr_q <= RW_LAST);
  wire [RW_IDX_BITS-1:0] cmd_idx = cmd_addr[RW_IDX_BITS-1:0];
  wire [RW_IDX_BITS-1:0] last_idx = last_addr_q[RW_IDX_BITS-1:0];

  // reply data: write echo, stored word, read-only input or zero
  wire data_t rd_value = last_is_rw ? rw_mem[last_idx] :
                         (last_is_ro ? i_ro_data : DATA_RESET);
  wire data_t reply_data = last_write_q ? last_data_q : rd_value;
  wire [STATUS_BITS-1:0] status_next = {{(STATUS_BITS-STATUS_USED){1'b0}}, i_status};

  ////////////////////////////////////////////////////////////////////////////
  // pin history for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sck_q <= 1'b1;
      sel_q <= 1'b1;
    end else begin
      sck_q <= link.sck;
      sel_q <= link.select_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 40-bit shift register, also the daisy chain delay line
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      shift_q <= FRAME_RESET;
    end else if (frame_start) begin
      shift_q <= reply_q;
    end else if (in_frame && sck_rise) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], link.mosi};
    end
  end

  // rising edge count, saturating once a full datagram is in
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bits_q <= '0;
    end else if (frame_start) begin
      bits_q <= '0;
    end else if (in_frame && sck_rise && !frame_ok) begin
      bits_q <= bits_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output: first bit at select, then one per falling edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= in_frame;
      if (frame_start) begin
        miso_q <= reply_q[FRAME_BITS-1];
      end else if (in_frame && sck_fall) begin
        miso_q <= shift_q[FRAME_BITS-1];
      end
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe = miso_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // command capture at select release
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pend_q <= 1'b0;
      last_write_q <= 1'b0;
      last_addr_q <= '0;
      last_data_q <= DATA_RESET;
    end else begin
      pend_q <= take_cmd;
      if (take_cmd) begin
        last_write_q <= cmd_write;
        last_addr_q <= cmd_addr;
        last_data_q <= cmd_data;
      end
    end
  end

  // reply word and status latched once the access completes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      reply_q <= FRAME_RESET;
    end else if (pend_q) begin
      reply_q <= {status_next, reply_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outward write strobe for every writable address
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_valid_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= DATA_RESET;
    end else begin
      wr_valid_q <= take_cmd & cmd_write & ~cmd_is_ro;
      if (take_cmd && cmd_write) begin
        wr_addr_q <= cmd_addr;
        wr_data_q <= cmd_data;
      end
    end
  end

  // read request for read-only addresses, answered on i_ro_data in the same cycle as the request
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
      drop_q <= 1'b0;
    end else begin
      rd_req_q <= take_cmd & ~cmd_write & cmd_is_ro;
      drop_q <= frame_end & ~frame_ok;
      if (take_cmd) begin
        rd_addr_q <= cmd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back store for the read-write class
  generate
    for (genvar g = 0; g < RW_DEPTH; g++) begin : g_rw
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          rw_mem[g] <= DATA_RESET;
        end else if (take_cmd && cmd_write && cmd_is_rw && (cmd_idx == g)) begin
          rw_mem[g] <= cmd_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // user side outputs
  assign o_wr_valid = wr_valid_q;
  assign o_wr_addr = wr_addr_q;
  assign o_wr_data = wr_data_q;
  assign o_rd_req = rd_req_q;
  assign o_rd_addr = rd_addr_q;
  assign o_frame_drop = drop_q;

endmodule

`default_nettype wire

/* pkg/spi_frame_pkg.sv */
// spi_frame_pkg: constants and types shared by both ends of the 40-bit
// datagram serial link.
// assumes one 125 MHz system clock on each end and sampled serial pins.
`default_nettype none

package spi_frame_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // datagram layout
  localparam int FRAME_BITS = 40;
  localparam int DATA_BITS = 32;
  localparam int ADDR_BITS = 7;
  localparam int STATUS_BITS = 8;
  localparam int STATUS_USED = 3;
  localparam int DIR_POS = 39;
  localparam int ADDR_MSB = 38;
  localparam int ADDR_LSB = 32;
  localparam int DATA_MSB = 31;
  localparam int COUNT_BITS = 6;

  typedef logic [FRAME_BITS-1:0] frame_t;
  typedef logic [DATA_BITS-1:0] data_t;
  typedef logic [ADDR_BITS-1:0] addr_t;
  typedef logic [COUNT_BITS-1:0] count_t;

  localparam count_t FRAME_COUNT = 6'h28;
  localparam frame_t FRAME_RESET = 40'h00_0000_0000;
  localparam data_t DATA_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // register classes by address
  localparam addr_t RO_LAST = 7'h0F;
  localparam addr_t RW_FIRST = 7'h10;
  localparam addr_t RW_LAST = 7'h1F;
  localparam int RW_DEPTH = 16;
  localparam int RW_IDX_BITS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // host timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_HALF_NS = 32;
  localparam int SEL_LEAD_NS = 40;
  localparam int SEL_GAP_NS = 80;
  localparam int TIMER_BITS = 5;
  typedef logic [TIMER_BITS-1:0] timer_t;
  localparam timer_t SCK_HALF_CYCLES =
    TIMER_BITS'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam timer_t SEL_LEAD_CYCLES =
    TIMER_BITS'((SEL_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
  localparam timer_t SEL_GAP_CYCLES =
    TIMER_BITS'((SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_TRAIL = 3'b100,
    ST_GAP = 3'b101
  } host_state_e;

endpackage

`default_nettype wire

/* pkg/spi_link_if.sv */
// spi_link_if: the four serial wires between master and device.
// assumes both ends share i_clk; the reply line idles high when undriven.
`default_nettype none

interface spi_link_if;
  logic sck;
  logic select_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // resolved reply wire, pulled high while the device is not driving
  assign miso_line = miso_oe ? miso : 1'b1;

  modport device (
    input sck,
    input select_low,
    input mosi,
    output miso,
    output miso_oe
  );

  modport host (
    output sck,
    output select_low,
    output mosi,
    input miso_line
  );
endinterface

`default_nettype wire

/* hdl/spi_host_end.sv */
// spi_host_end: master end of the datagram link, one 40-bit frame per start.
// assumes the device answers on miso_line in mode 3 timing.
`default_nettype none

module spi_host_end (
  input wire logic i_clk,
  input wire logic i_reset_n,
  spi_link_if.host link,
  input wire logic i_start,
  input wire spi_frame_pkg::frame_t i_cmd,
  output logic o_busy,
  output logic o_done,
  output spi_frame_pkg::frame_t o_reply
);
  import spi_frame_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  host_state_e state_q;
  timer_t timer_q;
  count_t bits_q;
  frame_t tx_q;
  frame_t rx_q;
  frame_t reply_q;
  logic sck_q;
  logic sel_low_q;
  logic mosi_q;
  logic busy_q;
  logic done_q;

  // divider tick ends each timed phase
  wire tick = (timer_q == '0);
  wire last_bit = (bits_q == FRAME_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      timer_q <= '0;
      bits_q <= '0;
      tx_q <= FRAME_RESET;
      rx_q <= FRAME_RESET;
      reply_q <= FRAME_RESET;
      sck_q <= 1'b1;
      sel_low_q <= 1'b1;
      mosi_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!tick) begin
        timer_q <= timer_q - 5'h01;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            tx_q <= i_cmd;
            bits_q <= '0;
            sel_low_q <= 1'b0;
            busy_q <= 1'b1;
            timer_q <= SEL_LEAD_CYCLES;
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            sck_q <= 1'b0;
            mosi_q <= tx_q[FRAME_BITS-1];
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
            timer_q <= SCK_HALF_CYCLES;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[FRAME_BITS-2:0], link.miso_line};
            bits_q <= bits_q + 6'h01;
            timer_q <= SCK_HALF_CYCLES;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick && last_bit) begin
            timer_q <= SEL_LEAD_CYCLES;
            state_q <= ST_TRAIL;
          end else if (tick) begin
            sck_q <= 1'b0;
            mosi_q <= tx_q[FRAME_BITS-1];
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
            timer_q <= SCK_HALF_CYCLES;
            state_q <= ST_LOW;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            sel_low_q <= 1'b1;
            timer_q <= SEL_GAP_CYCLES;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            reply_q <= rx_q;
            done_q <= 1'b1;
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and user outputs
  assign link.sck = sck_q;
  assign link.select_low = sel_low_q;
  assign link.mosi = mosi_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_reply = reply_q;

endmodule

`default_nettype wire

/* test/spi_link_sva.sv */
// spi_link_sva: wire checks on the link between the host and device ends.
// assumes its inputs come straight from one spi_link_if instance, one clock.
`default_nettype none

module spi_link_sva (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic sck,
  input wire logic select_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rises_q;
  logic [5:0] rises_d;
  logic sck_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // rising sck edges counted inside one frame, cleared while deselected
  assign rises_d = select_low ? 6'h00 : rises_q + 6'(sck & ~sck_q);

  // edge counter and delayed sck
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rises_q <= 6'h00;
      sck_q <= 1'b1;
    end else begin
      rises_q <= rises_d;
      sck_q <= sck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame length, clock idle level and select framing
  property p_forty;
    $rose(select_low) |-> rises_q == 6'h28;
  endproperty
  a_forty: assert property (p_forty) else $error("frame not 40 clocks");
  property p_idle;
    select_low |-> sck;
  endproperty
  a_idle: assert property (p_idle) else $error("sck low while idle");
  property p_lead;
    $fell(select_low) |-> sck [*5];
  endproperty
  a_lead: assert property (p_lead) else $error("sck before lead time");
  property p_low;
    $fell(sck) |-> !sck [*4] ##1 sck;
  endproperty
  a_low: assert property (p_low) else $error("sck low phase length");
  property p_high;
    $rose(sck) && rises_q < 6'h27 |-> sck [*4] ##1 !sck;
  endproperty
  a_high: assert property (p_high) else $error("sck high phase length");

  ////////////////////////////////////////////////////////////////////////////
  // data line timing on both directions
  property p_mosi;
    !select_low && $changed(mosi) |-> $fell(sck);
  endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved off falling sck");
  property p_oe_on;
    $fell(select_low) |=> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("reply not driven");
  property p_oe_off;
    $rose(select_low) |-> ##[1:2] !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("reply not released");
  property p_miso;
    miso_oe && $past(miso_oe) && $changed(miso) |-> !sck && !select_low;
  endproperty
  a_miso: assert property (p_miso) else $error("miso moved while sck high");
endmodule

`default_nettype wire

/* test/tb.sv */
// tb: host and device ends joined, plus a bit-driven link to a second device.
// assumes package, interface and both design ends are compiled before it.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_frame_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic i_start;
  logic o_busy;
  logic o_done;
  logic [2:0] i_status;
  frame_t i_cmd;
  frame_t o_reply;
  addr_t rd_a, rd_b, wa_a, wa_b;
  data_t wd_a, wd_b;
  logic wv_a, wv_b, rq_a, rq_b, dr_a, dr_b;
  data_t store [16] = '{default: 32'h0000_0000};
  int n_errors = 0;
  int check_count = 0;
  int nw = 0;
  int nd = 0;
  int nr = 0;
  int seed = 22;

  // read-only register contents as seen by the device ends
  function automatic data_t ro(input addr_t a);
    return {4{1'b1, a}};
  endfunction

  // data that the next reply must carry after command c
  function automatic data_t answer(input frame_t c);
    if (c[39]) return c[31:0];
    if (c[38:36] == 3'h0) return ro(c[38:32]);
    if (c[38:36] == 3'h1) return store[c[35:32]];
    return 32'h0000_0000;
  endfunction

  spi_link_if lk ();
  spi_link_if lk2 ();

  ////////////////////////////////////////////////////////////////////////////
  // both ends on the first link, a lone device end on the second
  spi_host_end spi_host_end_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(lk.host),
    .i_start(i_start), .i_cmd(i_cmd), .o_busy(o_busy), .o_done(o_done), .o_reply(o_reply));
  spi_dev_end spi_dev_end_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(lk.device),
    .i_status(i_status), .i_ro_data(ro(rd_a)), .o_wr_valid(wv_a), .o_wr_addr(wa_a),
    .o_wr_data(wd_a), .o_rd_req(rq_a), .o_rd_addr(rd_a), .o_frame_drop(dr_a));
  spi_dev_end spi_dev_end_inst_b (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(lk2.device),
    .i_status(i_status), .i_ro_data(ro(rd_b)), .o_wr_valid(wv_b), .o_wr_addr(wa_b),
    .o_wr_data(wd_b), .o_rd_req(rq_b), .o_rd_addr(rd_b), .o_frame_drop(dr_b));
  spi_link_sva spi_link_sva_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .sck(lk.sck),
    .select_low(lk.select_low), .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));

  // clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // strobe counters of both device ends
  always @(posedge i_clk) begin
    nw <= nw + int'(wv_a === 1'b1) + int'(wv_b === 1'b1);
    nd <= nd + int'(dr_a === 1'b1) + int'(dr_b === 1'b1);
    nr <= nr + int'(rq_a === 1'b1) + int'(rq_b === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, report and finish
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one host frame, bounded wait for its completion
  task automatic xfer(input frame_t c);
    int k;
    k = 0;
    @(negedge i_clk);
    i_cmd = c;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    chk("busy", 40'(o_busy), 40'h00_0000_0001);
    while (o_done !== 1'b1) begin
      @(negedge i_clk);
      k++;
      if (k > 1000) begin
        n_errors++;
        complete_run();
      end
    end
    chk("idle", 40'(o_busy), 40'h00_0000_0000);
  endtask

  // bit-driven frame of n bits on the second link, reply bits collected
  task automatic bang(input int n, input logic [79:0] v, output logic [79:0] got);
    got = '0;
    @(negedge i_clk);
    lk2.select_low = 1'b0;
    repeat (5) @(negedge i_clk);
    for (int b = n - 1; b >= 0; b--) begin
      lk2.sck = 1'b0;
      lk2.mosi = v[b];
      repeat (4) @(negedge i_clk);
      lk2.sck = 1'b1;
      got = {got[78:0], lk2.miso_line};
      repeat (4) @(negedge i_clk);
    end
    lk2.select_low = 1'b1;
    lk2.mosi = ~lk2.mosi;
    repeat (12) @(negedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    frame_t c;
    frame_t exp;
    frame_t corner [6];
    logic [79:0] got;
    logic [2:0] st;
    int w0, r0, d0;
    corner = '{40'h9F_FFFF_FFFF, 40'h80_1234_5678, 40'h1F_0000_0000,
      40'h0F_0000_0000, 40'h20_0000_0000, 40'hA0_CAFE_F00D};
    exp = 40'h00_0000_0000;
    i_reset_n = 1'b0;
    i_start = 1'b0;
    i_cmd = 40'h00_0000_0000;
    i_status = 3'h0;
    lk2.sck = 1'b1;
    lk2.select_low = 1'b1;
    lk2.mosi = 1'b1;
    repeat (8) @(negedge i_clk);
    i_reset_n = 1'b1;
    // corner frames, then random ones through the host end
    for (int k = 0; k < 30; k++) begin
      c = {8'($random(seed)), 32'($random(seed))};
      if (k < 6) c = corner[k];
      else if (k % 3 != 2) c[38:37] = 2'b00;
      st = 3'($random(seed));
      i_status = st;
      w0 = nw;
      r0 = nr;
      xfer(c);
      chk("reply", o_reply, exp);
      chk("write strobes", 40'(nw - w0), 40'(c[39] && c[38:36] != 3'h0));
      chk("read strobes", 40'(nr - r0), 40'(!c[39] && c[38:36] == 3'h0));
      if (c[39] && c[38:36] != 3'h0) chk("write word", {1'b1, wa_a, wd_a}, c);
      exp = {5'h00, st, answer(c)};
      if (c[39] && c[38:36] == 3'h1) store[c[35:32]] = c[31:0];
    end
    $display("host frames finished");
    // second link: full write, short frame, then an 80-bit chained frame
    i_status = 3'h5;
    bang(40, {40'h00_0000_0000, 40'h90_1111_2222}, got);
    chk("first reply", got[39:0], 40'h00_0000_0000);
    w0 = nw;
    d0 = nd;
    bang(39, {16'h0000, 32'($random(seed)), 32'($random(seed))}, got);
    chk("drop count", 40'(nd - d0), 40'h00_0000_0001);
    chk("short writes", 40'(nw - w0), 40'h00_0000_0000);
    bang(80, {40'h10_0000_0000, 40'h91_3333_4444}, got);
    chk("chained reply", got, {8'h05, 32'h1111_2222, 40'h10_0000_0000});
    chk("last forty taken", {1'b1, wa_b, wd_b}, 40'h91_3333_4444);
    chk("chained writes", 40'(nw - w0), 40'h00_0000_0001);
    $display("second link finished");
    complete_run();
  end
endmodule

`default_nettype wire
